// ==== src/gspm_pin_mux.sv ====
// Purpose: role selection for port 0 pins with LED driver and pad options
// Assumes: all pin and debug inputs are synchronous to clk_sys_i
// Notes:   pad outputs are registered, one cycle behind their causes
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - fixed priority per pin, top role wins
// - pin 0: programming voltage, crystal, else input
// - pin 3 carries reference clock when enabled
// - debug transaction takes pin 4 data line
// - clock output on pin 4, pin 6 or both
// - pin 5 is debug clock unless LED on
// - LED role: actual drive in status bit
// - two-bit LED current level, three levels
// - port bit 5 switches LED on, off
// - LED on disables pin 5 pulldown
// - pin 5 open drain only in debug
// - strobe fall latches matrix and pullup-off
// - option read returns latched pad values
// - matrix: pins 3..1 pulled low in shutdown
// - drive bit: 0 open drain, 1 push-pull
module gspm_pin_mux (
  input  wire logic                        clk_sys_i,
  input  wire logic                        resetn_i,
  // avalon-mm slave
  input  wire logic [gspm_pkg::ADDR_W-1:0] avs_address_i,
  input  wire logic                        avs_read_i,
  input  wire logic                        avs_write_i,
  input  wire logic [31:0]                 avs_writedata_i,
  input  wire logic [3:0]                  avs_byteenable_i,
  output logic      [31:0]                 avs_readdata_o,
  output logic                             avs_waitrequest_o,
  // pads
  input  wire logic [7:0]                  pin_in_i,
  output logic      [7:0]                  pin_out_o,
  output logic      [7:0]                  pin_oe_n_o,
  output logic      [7:0]                  pin_pullup_en_o,
  output logic      [7:0]                  pin_pulldown_o,
  input  wire logic                        shutdown_i,
  // special sources and sinks
  input  wire logic                        vpp_present_i,
  input  wire logic                        clk_ref_i,
  input  wire logic                        clk_out_src_i,
  output logic                             crystal_osc_enable_o,
  output logic      [1:0]                  led_current_level_o,
  output logic                             led_drive_actual_o,
  // debug adapter side
  input  wire logic                        debug_session_i,
  input  wire logic                        debug_txn_i,
  input  wire logic                        debug_data_out_i,
  input  wire logic                        debug_data_oe_i,
  input  wire logic                        debug_led_disable_i,
  output logic                             debug_data_pin_o,
  output logic                             debug_clock_pin_o
);
  import gspm_pkg::*;

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [7:0]    port0_value_reg,        port0_value_next;
  logic [7:0]    port0_drive_config_reg, port0_drive_config_next;
  logic [1:0]    led_current_level_reg,  led_current_level_next;
  gspm_pad_opt_s opt_wr_reg,             opt_wr_next;
  logic          strobe_reg,             strobe_next;
  logic          ref_clock_pin_enable_reg, ref_clock_pin_enable_next;
  logic          clock_out_enable_reg,   clock_out_enable_next;
  logic [1:0]    clock_out_pin_select_reg, clock_out_pin_select_next;
  logic          crystal_osc_enable_reg, crystal_osc_enable_next;
  logic          ack_reg,                ack_next;
  logic [31:0]   rdata_reg,              rdata_next;
  gspm_pad_opt_s opt_latched;
  logic          led_on;
  logic          req;
  logic          wr_fire;
  logic [7:0]    port0_read;

  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h00_0000, b};
  endfunction

  // ****************************************************************
  // bus slave
  // ****************************************************************
  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_reg;
  assign wr_fire           = avs_write_i & ack_reg & avs_byteenable_i[0];
  assign avs_readdata_o    = rdata_reg;

  // led pin reads the intended drive, not the pin level
  always_comb begin
    port0_read    = pin_in_i;
    port0_read[5] = port0_value_reg[5] & (|led_current_level_reg);
  end

  always_comb begin
    ack_next   = req & ~ack_reg;
    rdata_next = rdata_reg;
    if (avs_read_i && !ack_reg) begin
      unique case (avs_address_i)
        OFS_PORT0_VALUE:     rdata_next = byte_word(port0_read);
        OFS_PORT0_DRIVE_CFG: rdata_next = byte_word(port0_drive_config_reg);
        OFS_OPTION_CTRL:     rdata_next = byte_word({strobe_reg, opt_latched.matrix,
                                           opt_latched.roff, 3'b000,
                                           led_current_level_reg});
        OFS_SPECIAL_SET:     rdata_next = byte_word({4'h0, clock_out_pin_select_reg,
                                           clock_out_enable_reg,
                                           ref_clock_pin_enable_reg});
        OFS_CRYSTAL_CTRL:    rdata_next = byte_word({7'h00, crystal_osc_enable_reg});
        OFS_MISC_STATUS:     rdata_next = byte_word({7'h00, led_on});
        default:             rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    port0_value_next          = port0_value_reg;
    port0_drive_config_next   = port0_drive_config_reg;
    led_current_level_next    = led_current_level_reg;
    opt_wr_next               = opt_wr_reg;
    strobe_next               = strobe_reg;
    ref_clock_pin_enable_next = ref_clock_pin_enable_reg;
    clock_out_enable_next     = clock_out_enable_reg;
    clock_out_pin_select_next = clock_out_pin_select_reg;
    crystal_osc_enable_next   = crystal_osc_enable_reg;
    if (wr_fire) begin
      unique case (avs_address_i)
        OFS_PORT0_VALUE: begin
          port0_value_next = {avs_writedata_i[7:1], 1'b1};
        end
        OFS_PORT0_DRIVE_CFG: begin
          port0_drive_config_next = avs_writedata_i[7:0];
        end
        OFS_OPTION_CTRL: begin
          strobe_next            = avs_writedata_i[BIT_OPT_STROBE];
          opt_wr_next.matrix     = avs_writedata_i[BIT_OPT_MATRIX];
          opt_wr_next.roff       = avs_writedata_i[BIT_OPT_ROFF];
          led_current_level_next = avs_writedata_i[BIT_LED_LVL_LO +: 2];
        end
        OFS_SPECIAL_SET: begin
          ref_clock_pin_enable_next = avs_writedata_i[BIT_SET_REFEN];
          clock_out_enable_next     = avs_writedata_i[BIT_SET_CLKEN];
          clock_out_pin_select_next = avs_writedata_i[BIT_SET_SEL_LO +: 2];
        end
        OFS_CRYSTAL_CTRL: begin
          crystal_osc_enable_next = avs_writedata_i[BIT_XO_ENABLE];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port0_value_reg          <= RST_PORT0_VALUE;
      port0_drive_config_reg   <= RST_DRIVE_CFG;
      led_current_level_reg    <= RST_LED_LEVEL;
      opt_wr_reg               <= '0;
      strobe_reg               <= 1'b0;
      ref_clock_pin_enable_reg <= 1'b0;
      clock_out_enable_reg     <= 1'b0;
      clock_out_pin_select_reg <= RST_CLK_SEL;
      crystal_osc_enable_reg   <= 1'b0;
      ack_reg                  <= 1'b0;
      rdata_reg                <= 32'h0000_0000;
    end else begin
      port0_value_reg          <= port0_value_next;
      port0_drive_config_reg   <= port0_drive_config_next;
      led_current_level_reg    <= led_current_level_next;
      opt_wr_reg               <= opt_wr_next;
      strobe_reg               <= strobe_next;
      ref_clock_pin_enable_reg <= ref_clock_pin_enable_next;
      clock_out_enable_reg     <= clock_out_enable_next;
      clock_out_pin_select_reg <= clock_out_pin_select_next;
      crystal_osc_enable_reg   <= crystal_osc_enable_next;
      ack_reg                  <= ack_next;
      rdata_reg                <= rdata_next;
    end
  end

  // ****************************************************************
  // pad option latch
  // ****************************************************************
  gspm_opt_latch u_opt_latch (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .strobe_i  (strobe_reg),
    .wr_opt_i  (opt_wr_reg),
    .latched_o (opt_latched)
  );

  // ****************************************************************
  // role selection
  // ****************************************************************
  // host disable keeps the led dark while it debugs
  assign led_on = port0_value_reg[5] & (|led_current_level_reg)
                  & ~debug_led_disable_i;

  gspm_pad_drv_s drv_reg, drv_next;
  logic [7:0]    pullup_reg, pullup_next;
  logic [7:0]    pulldown_reg, pulldown_next;
  logic          xo_reg, xo_next;
  logic          led_drive_reg, led_drive_next;
  logic          dbg_data_reg, dbg_data_next;
  logic          dbg_clk_reg, dbg_clk_next;

  always_comb begin
    // plain port behaviour per pin
    for (int i = 0; i < 8; i++) begin
      drv_next.out[i]  = port0_value_reg[i];
      drv_next.oe_n[i] = ~port0_drive_config_reg[i] & port0_value_reg[i];
    end
    // pin 0 never drives; vpp outranks crystal
    drv_next.out[0]  = 1'b1;
    drv_next.oe_n[0] = 1'b1;
    xo_next          = crystal_osc_enable_reg & ~vpp_present_i;
    if (ref_clock_pin_enable_reg) begin
      drv_next.out[3]  = clk_ref_i;
      drv_next.oe_n[3] = 1'b0;
    end
    if (debug_txn_i) begin
      drv_next.out[4]  = debug_data_out_i;
      drv_next.oe_n[4] = ~debug_data_oe_i;
    end else if (clock_out_enable_reg && clock_out_pin_select_reg[0]) begin
      drv_next.out[4]  = clk_out_src_i;
      drv_next.oe_n[4] = 1'b0;
    end
    // led role owns pin 5 outside debug; current sink drives it
    if (debug_session_i) begin
      drv_next.out[5]  = 1'b0;
      drv_next.oe_n[5] = port0_value_reg[5] | led_on;
    end else begin
      drv_next.out[5]  = 1'b0;
      drv_next.oe_n[5] = 1'b1;
    end
    if (clock_out_enable_reg && clock_out_pin_select_reg[1]) begin
      drv_next.out[6]  = clk_out_src_i;
      drv_next.oe_n[6] = 1'b0;
    end
    // pad options bypass the role priority entirely
    pullup_next   = ~((opt_latched.roff ? PINS_ROFF : 8'h00)
                      | (opt_latched.matrix ? PINS_MATRIX : 8'h00));
    pulldown_next = (opt_latched.matrix && shutdown_i) ? PINS_MATRIX : 8'h00;
    led_drive_next = led_on;
    dbg_data_next  = pin_in_i[4];
    dbg_clk_next   = led_on ? 1'b1 : pin_in_i[5];
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      drv_reg       <= '{out: 8'hFF, oe_n: 8'hFF};
      pullup_reg    <= 8'hFF;
      pulldown_reg  <= 8'h00;
      xo_reg        <= 1'b0;
      led_drive_reg <= 1'b0;
      dbg_data_reg  <= 1'b1;
      dbg_clk_reg   <= 1'b1;
    end else begin
      drv_reg       <= drv_next;
      pullup_reg    <= pullup_next;
      pulldown_reg  <= pulldown_next;
      xo_reg        <= xo_next;
      led_drive_reg <= led_drive_next;
      dbg_data_reg  <= dbg_data_next;
      dbg_clk_reg   <= dbg_clk_next;
    end
  end

  assign pin_out_o            = drv_reg.out;
  assign pin_oe_n_o           = drv_reg.oe_n;
  assign pin_pullup_en_o      = pullup_reg;
  assign pin_pulldown_o       = pulldown_reg;
  assign crystal_osc_enable_o = xo_reg;
  assign led_current_level_o  = led_current_level_reg;
  assign led_drive_actual_o   = led_drive_reg;
  assign debug_data_pin_o     = dbg_data_reg;
  assign debug_clock_pin_o    = dbg_clk_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  pin0_input_only_a : assert property (pin_oe_n_o[0])
    else $error("pin 0 driven");

  vpp_over_xo_a : assert property ($past(vpp_present_i) |-> !crystal_osc_enable_o)
    else $error("crystal enabled while programming voltage present");

  ref_clk_pin_a : assert property ($past(ref_clock_pin_enable_reg) |->
    (!pin_oe_n_o[3] && pin_out_o[3] == $past(clk_ref_i)))
    else $error("pin 3 not carrying reference clock");

  debug_data_steal_a : assert property ($past(debug_txn_i) |->
    (pin_out_o[4] == $past(debug_data_out_i)
     && pin_oe_n_o[4] == !$past(debug_data_oe_i)))
    else $error("pin 4 not given to debug transaction");

  clk_out_pin6_a : assert property ($past(clock_out_enable_reg && clock_out_pin_select_reg[1])
    |-> (!pin_oe_n_o[6] && pin_out_o[6] == $past(clk_out_src_i)))
    else $error("clock output missing on pin 6");

  led_pin_release_a : assert property (!debug_session_i ##1 1 |-> pin_oe_n_o[5])
    else $error("pin 5 driven outside debug session");

  led_host_off_a : assert property (debug_led_disable_i |=> !led_drive_actual_o)
    else $error("led driven while host disables it");

  led_no_pulldown_a : assert property ($past(led_on) |-> pin_oe_n_o[5])
    else $error("pin 5 pulled low while led on");

  matrix_pulldown_a : assert property ($past(opt_latched.matrix && shutdown_i)
    |-> (pin_pulldown_o == PINS_MATRIX && (pin_pullup_en_o & PINS_MATRIX) == 8'h00))
    else $error("matrix pins not pulled low in shutdown");

  bus_one_wait_a : assert property ($rose(req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("bus answer not after one wait cycle");

endmodule : gspm_pin_mux // gspm_pin_mux
`default_nettype wire

// ==== src/gspm_pkg.sv ====
// Purpose: shared constants and carriers of the pin role selection block
// Assumes: 32-bit Avalon-MM register slave with byte addresses
// Notes:   all offsets, field positions and the port, drive, LED level and clock select reset values live here
package gspm_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam int unsigned ADDR_W = 5;

  localparam logic [ADDR_W-1:0] OFS_PORT0_VALUE     = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_PORT0_DRIVE_CFG = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_OPTION_CTRL     = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_SPECIAL_SET     = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_CRYSTAL_CTRL    = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_MISC_STATUS     = 5'h14;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned BIT_OPT_STROBE  = 7;
  localparam int unsigned BIT_OPT_MATRIX  = 6;
  localparam int unsigned BIT_OPT_ROFF    = 5;
  localparam int unsigned BIT_LED_LVL_LO  = 0;
  localparam int unsigned BIT_SET_REFEN   = 0;
  localparam int unsigned BIT_SET_CLKEN   = 1;
  localparam int unsigned BIT_SET_SEL_LO  = 2;
  localparam int unsigned BIT_XO_ENABLE   = 0;
  localparam int unsigned BIT_LED_ACTUAL  = 0;

  // ****************************************************************
  // reset values and pad option pin masks
  // ****************************************************************
  localparam logic [7:0] RST_PORT0_VALUE = 8'hDF;
  localparam logic [7:0] RST_DRIVE_CFG   = 8'h00;
  localparam logic [1:0] RST_LED_LEVEL   = 2'h0;
  localparam logic [1:0] RST_CLK_SEL     = 2'h0;
  localparam logic [7:0] PINS_MATRIX     = 8'h0E;
  localparam logic [7:0] PINS_ROFF       = 8'h06;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic matrix;
    logic roff;
  } gspm_pad_opt_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } gspm_pad_drv_s;

endpackage : gspm_pkg

// ==== src/gspm_opt_latch.sv ====
// Purpose: pad option latch for the matrix and pullup-off options
// Assumes: strobe is a register bit written by software
// Notes:   new values are taken when the strobe falls after a rise
`timescale 1ns/100ps
`default_nettype none
module gspm_opt_latch (
  input  wire logic                    clk_sys_i,
  input  wire logic                    resetn_i,
  input  wire logic                    strobe_i,
  input  wire gspm_pkg::gspm_pad_opt_s wr_opt_i,
  output var  gspm_pkg::gspm_pad_opt_s latched_o
);
  import gspm_pkg::*;

  logic          strobe_prev_reg;
  logic          strobe_prev_next;
  gspm_pad_opt_s opt_reg;
  gspm_pad_opt_s opt_next;

  always_comb begin
    strobe_prev_next = strobe_i;
    opt_next         = opt_reg;
    if (strobe_prev_reg && !strobe_i) begin
      opt_next = wr_opt_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strobe_prev_reg <= 1'b0;
      opt_reg         <= '0;
    end else begin
      strobe_prev_reg <= strobe_prev_next;
      opt_reg         <= opt_next;
    end
  end

  assign latched_o = opt_reg;

  opt_latch_take_a : assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (strobe_prev_reg && !strobe_i) |=> (opt_reg == $past(wr_opt_i)))
    else $error("pad option latch missed a strobe fall");

  opt_latch_hold_a : assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !(strobe_prev_reg && !strobe_i) |=> $stable(opt_reg))
    else $error("pad option latch changed without a strobe fall");

endmodule : gspm_opt_latch // gspm_opt_latch
`default_nettype wire

// ==== dv/gspm_partner.sv ====
// Purpose: board and debug adapter model facing the pads
// Assumes: one clock; pads are resolved every cycle
// Notes:   a released pin without button or pullup toggles every cycle
`timescale 1ns/100ps
`default_nettype none
module gspm_partner (
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  input  wire logic [7:0] pin_out_i,
  input  wire logic [7:0] pin_oe_n_i,
  input  wire logic [7:0] pin_pullup_en_i,
  input  wire logic [7:0] button_i,
  input  wire logic       led_drive_actual_i,
  input  wire logic       connect_i,
  input  wire logic       led_ovr_i,
  input  wire logic       txn_i,
  input  wire logic       data_i,
  output logic      [7:0] pin_in_o,
  output logic            session_o,
  output logic            txn_o,
  output logic            data_out_o,
  output logic            data_oe_o,
  output logic            led_disable_o
);
  logic flip_reg;
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flip_reg  <= 1'b0;
      session_o <= 1'b0;
    end else begin
      flip_reg <= ~flip_reg;
      if (!connect_i) session_o <= 1'b0;
      else if (!led_drive_actual_i) session_o <= 1'b1;
    end
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in_o[i] = !pin_oe_n_i[i] ? pin_out_i[i] : button_i[i] ? 1'b0 :
                    pin_pullup_en_i[i] ? 1'b1 : flip_reg;
    end
  end
  // host keeps the LED off in a session unless told otherwise
  assign led_disable_o = session_o & ~led_ovr_i;
  assign txn_o         = session_o & txn_i;
  assign data_oe_o     = txn_o;
  assign data_out_o    = txn_o ? data_i : flip_reg;
endmodule // gspm_partner
`default_nettype wire

// ==== dv/gspm_pin_mux_tb_top.sv ====
// Purpose: self-checking bench of the pin role selection block
// Assumes: pads follow their causes one clock later
// Notes:   register rows first, then hand-written pin cases
`timescale 1ns/100ps
`default_nettype none
module gspm_pin_mux_tb_top;
  import gspm_pkg::*;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic [7:0]        exp;
  } gspm_row_s;
  logic clk_sys, resetn, avs_read, avs_write, avs_wait, vpp, clk_ref, clk_src, shutdown;
  logic connect, led_ovr, txn, data, xo_en, led_act, session, dtxn, d_out, d_oe, led_dis;
  logic dbg_clk, dbg_data;
  logic [ADDR_W-1:0] avs_addr;
  logic [31:0]       avs_wdata, avs_rdata, rd;
  logic [3:0]        avs_be;
  logic [7:0]        pin_in, pin_out, pin_oe_n, pin_pu, pin_pd, button;
  logic [1:0]        led_lvl;
  int                failures, checks;
  gspm_row_s rows [6] = '{{OFS_PORT0_DRIVE_CFG, 8'hA5, 8'hA5}, {OFS_PORT0_DRIVE_CFG,
    8'h00, 8'h00}, {OFS_OPTION_CTRL, 8'h03, 8'h03}, {OFS_OPTION_CTRL, 8'h01, 8'h01},
    {OFS_OPTION_CTRL, 8'h00, 8'h00}, {5'h18, 8'hFF, 8'h00}};

  gspm_pin_mux dut (.clk_sys_i(clk_sys), .resetn_i(resetn), .avs_address_i(avs_addr),
    .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_wdata),
    .avs_byteenable_i(avs_be), .avs_readdata_o(avs_rdata), .avs_waitrequest_o(avs_wait),
    .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_n_o(pin_oe_n), .pin_pullup_en_o(pin_pu),
    .pin_pulldown_o(pin_pd), .shutdown_i(shutdown), .vpp_present_i(vpp),
    .clk_ref_i(clk_ref), .clk_out_src_i(clk_src), .crystal_osc_enable_o(xo_en),
    .led_current_level_o(led_lvl), .led_drive_actual_o(led_act),
    .debug_session_i(session), .debug_txn_i(dtxn), .debug_data_out_i(d_out),
    .debug_data_oe_i(d_oe), .debug_led_disable_i(led_dis), .debug_data_pin_o(dbg_data),
    .debug_clock_pin_o(dbg_clk));
  gspm_partner partner (.clk_sys_i(clk_sys), .resetn_i(resetn), .pin_out_i(pin_out),
    .pin_oe_n_i(pin_oe_n), .pin_pullup_en_i(pin_pu), .button_i(button),
    .led_drive_actual_i(led_act), .connect_i(connect), .led_ovr_i(led_ovr), .txn_i(txn),
    .data_i(data), .pin_in_o(pin_in), .session_o(session), .txn_o(dtxn),
    .data_out_o(d_out), .data_oe_o(d_oe), .led_disable_o(led_dis));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic end_of_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk_pad(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [7:0] exp);
    checks++;
    if (rd !== {24'h00_0000, exp}) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, rd, {24'h00_0000, exp});
    end
  endtask
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    logic ok;
    ok = 1'b0;
    @(posedge clk_sys);
    avs_read  <= ~wr;
    avs_write <= wr;
    avs_addr  <= a;
    avs_wdata <= {24'h00_0000, d};
    avs_be    <= be;
    for (int n = 0; n < 20 && !ok; n++) begin
      #1;
      ok = (avs_wait === 1'b0);
      rd = avs_rdata;
      @(posedge clk_sys);
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (!ok) begin
      failures++;
      end_of_test();
    end
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {avs_read, avs_write, vpp, clk_ref, clk_src, shutdown, connect, led_ovr, txn, data} = '0;
    avs_addr  = '0;
    avs_wdata = '0;
    avs_be    = 4'hF;
    button    = 8'h00;
    resetn    = 1'b0;
    failures  = 0;
    checks    = 0;
    repeat (10) @(posedge clk_sys);
    #1;
    chk_pad(pin_oe_n, 8'hFF);
    chk_pad(pin_pd, 8'h00);
    @(posedge clk_sys);
    resetn <= 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      bus(1'b1, rows[i].addr, rows[i].wdata, 4'hF);
      bus(1'b0, rows[i].addr, 8'h00, 4'hF);
      chk_rd(rows[i].exp);
    end
    bus(1'b1, OFS_PORT0_DRIVE_CFG, 8'hFF, 4'hE);
    bus(1'b0, OFS_PORT0_DRIVE_CFG, 8'h00, 4'hF);
    chk_rd(8'h00);
    $display("test registers done");
    bus(1'b1, OFS_CRYSTAL_CTRL, 8'h01, 4'hF);
    settle();
    chk_pad(8'(xo_en), 8'h01);
    vpp <= 1'b1;
    settle();
    chk_pad(8'(xo_en), 8'h00);
    vpp <= 1'b0;
    bus(1'b1, OFS_CRYSTAL_CTRL, 8'h00, 4'hF);
    bus(1'b1, OFS_PORT0_VALUE, 8'hDE, 4'hF);
    settle();
    chk_pad(pin_oe_n, 8'hFF);
    bus(1'b1, OFS_PORT0_VALUE, 8'h5E, 4'hF);
    bus(1'b1, OFS_PORT0_DRIVE_CFG, 8'hC0, 4'hF);
    settle();
    chk_pad(8'({pin_oe_n[7:6], pin_out[7:6]}), 8'h01);
    bus(1'b1, OFS_PORT0_DRIVE_CFG, 8'h00, 4'hF);
    bus(1'b1, OFS_PORT0_VALUE, 8'hD6, 4'hF);
    $display("test pin0 and drive done");
    clk_ref <= 1'b1;
    bus(1'b1, OFS_SPECIAL_SET, 8'h01, 4'hF);
    settle();
    chk_pad(8'({pin_oe_n[3], pin_out[3]}), 8'h01);
    clk_ref <= 1'b0;
    bus(1'b1, OFS_PORT0_VALUE, 8'hDE, 4'hF);
    settle();
    chk_pad(8'({pin_oe_n[3], pin_out[3]}), 8'h00);
    bus(1'b1, OFS_SPECIAL_SET, 8'h0E, 4'hF);
    clk_src <= 1'b1;
    settle();
    chk_pad(8'({pin_oe_n[6], pin_out[6], pin_oe_n[4], pin_out[4]}), 8'h05);
    connect <= 1'b1;
    txn     <= 1'b1;
    settle();
    chk_pad(8'({pin_oe_n[6], pin_out[6], pin_oe_n[4], pin_out[4]}), 8'h04);
    chk_pad(8'(dbg_data), 8'h00);
    txn <= 1'b0;
    settle();
    chk_pad(8'({pin_oe_n[4], pin_out[4]}), 8'h01);
    bus(1'b1, OFS_SPECIAL_SET, 8'h00, 4'hF);
    $display("test clocks and debug data done");
    bus(1'b1, OFS_OPTION_CTRL, 8'h02, 4'hF);
    settle();
    chk_pad(8'({pin_oe_n[5], pin_out[5]}), 8'h00);
    bus(1'b1, OFS_PORT0_VALUE, 8'hFE, 4'hF);
    settle();
    chk_pad(8'({pin_oe_n[5], led_act}), 8'h02);
    led_ovr <= 1'b1;
    settle();
    chk_pad(8'({led_act, dbg_clk}), 8'h03);
    connect <= 1'b0;
    led_ovr <= 1'b0;
    settle();
    chk_pad(8'({led_act, pin_oe_n[5], led_lvl}), 8'h0E);
    bus(1'b0, OFS_MISC_STATUS, 8'h00, 4'hF);
    chk_rd(8'h01);
    for (int l = 1; l < 4; l++) begin
      bus(1'b1, OFS_OPTION_CTRL, 8'(l), 4'hF);
      settle();
      chk_pad(8'({led_act, led_lvl}), 8'(4 + l));
    end
    bus(1'b1, OFS_PORT0_VALUE, 8'hDE, 4'hF);
    settle();
    chk_pad(8'(led_act), 8'h00);
    button <= 8'h02;
    bus(1'b0, OFS_PORT0_VALUE, 8'h00, 4'hF);
    chk_rd(8'hDD);
    $display("test led done");
    bus(1'b1, OFS_OPTION_CTRL, 8'h40, 4'hF);
    bus(1'b0, OFS_OPTION_CTRL, 8'h00, 4'hF);
    chk_rd(8'h00);
    bus(1'b1, OFS_OPTION_CTRL, 8'hC0, 4'hF);
    bus(1'b1, OFS_OPTION_CTRL, 8'h40, 4'hF);
    settle();
    bus(1'b0, OFS_OPTION_CTRL, 8'h00, 4'hF);
    chk_rd(8'h40);
    chk_pad(8'(pin_pu[3:1]), 8'h00);
    shutdown <= 1'b1;
    bus(1'b1, OFS_SPECIAL_SET, 8'h01, 4'hF);
    settle();
    chk_pad(pin_pd, 8'h0E);
    bus(1'b1, OFS_OPTION_CTRL, 8'h20, 4'hF);
    bus(1'b1, OFS_OPTION_CTRL, 8'hA0, 4'hF);
    bus(1'b1, OFS_OPTION_CTRL, 8'h20, 4'hF);
    settle();
    bus(1'b0, OFS_OPTION_CTRL, 8'h00, 4'hF);
    chk_rd(8'h20);
    chk_pad(8'({pin_pu[3:1], pin_pd[3:1]}), 8'h20);
    $display("test pad options done");
    end_of_test();
  end
endmodule // gspm_pin_mux_tb_top
`default_nettype wire
